// ---- fqg_pkg.sv ----
// shared constants and types for the flash query geometry table
package fqg_pkg;

   // word address window served by this table
   localparam logic [7:0] FQG_ADDR_FIRST = 8'h1B;
   localparam logic [7:0] FQG_ADDR_LAST  = 8'h38;

   // system interface offsets
   localparam logic [7:0] FQG_A_VCC_MIN  = 8'h1B;
   localparam logic [7:0] FQG_A_VCC_MAX  = 8'h1C;
   localparam logic [7:0] FQG_A_VPP_MIN  = 8'h1D;
   localparam logic [7:0] FQG_A_VPP_MAX  = 8'h1E;
   localparam logic [7:0] FQG_A_TWP_TYP  = 8'h1F;
   localparam logic [7:0] FQG_A_TBW_TYP  = 8'h20;
   localparam logic [7:0] FQG_A_TBE_TYP  = 8'h21;
   localparam logic [7:0] FQG_A_TCE_TYP  = 8'h22;
   localparam logic [7:0] FQG_A_TWP_MAX  = 8'h23;
   localparam logic [7:0] FQG_A_TBW_MAX  = 8'h24;
   localparam logic [7:0] FQG_A_TBE_MAX  = 8'h25;
   localparam logic [7:0] FQG_A_TCE_MAX  = 8'h26;

   // geometry offsets
   localparam logic [7:0] FQG_A_SIZE     = 8'h27;
   localparam logic [7:0] FQG_A_IFC_LO   = 8'h28;
   localparam logic [7:0] FQG_A_IFC_HI   = 8'h29;
   localparam logic [7:0] FQG_A_WBUF_LO  = 8'h2A;
   localparam logic [7:0] FQG_A_WBUF_HI  = 8'h2B;
   localparam logic [7:0] FQG_A_NREG     = 8'h2C;
   localparam logic [7:0] FQG_A_REG1     = 8'h2D;
   localparam logic [7:0] FQG_A_REG2     = 8'h31;
   localparam logic [7:0] FQG_A_RSVD     = 8'h35;

   // system interface values
   localparam logic [7:0] FQG_V_VCC_MIN  = 8'h23;
   localparam logic [7:0] FQG_V_VCC_MAX  = 8'h36;
   localparam logic [7:0] FQG_V_VPP_MIN  = 8'h85;
   localparam logic [7:0] FQG_V_VPP_MAX  = 8'h95;
   localparam logic [7:0] FQG_V_TWP_TYP  = 8'h09;
   localparam logic [7:0] FQG_V_TBW_TYP  = 8'h0A;
   localparam logic [7:0] FQG_V_TBE_TYP  = 8'h0A;
   localparam logic [7:0] FQG_V_TCE      = 8'h00;
   localparam logic [7:0] FQG_V_TWP_MAX  = 8'h01;
   localparam logic [7:0] FQG_V_TBW_MAX  = 8'h02;
   localparam logic [7:0] FQG_V_TBE_MAX  = 8'h02;

   // geometry values
   localparam logic [7:0] FQG_V_SIZE_512M = 8'h1A;
   localparam logic [7:0] FQG_V_SIZE_1G   = 8'h1B;
   localparam logic [7:0] FQG_V_IFC_LO    = 8'h01;
   localparam logic [7:0] FQG_V_IFC_HI    = 8'h00;
   localparam logic [7:0] FQG_V_WBUF_LO   = 8'h0A;
   localparam logic [7:0] FQG_V_WBUF_HI   = 8'h00;
   localparam logic [7:0] FQG_V_NREG_PARM = 8'h02;
   localparam logic [7:0] FQG_V_NREG_SYM  = 8'h01;
   localparam logic [7:0] FQG_V_ZERO      = 8'h00;

   // region descriptors {z, y}: block count y+1, block size z*256
   localparam logic [31:0] FQG_D_MAIN_512M = 32'h0200_01FE;
   localparam logic [31:0] FQG_D_MAIN_1G   = 32'h0200_03FE;
   localparam logic [31:0] FQG_D_PARM      = 32'h0080_0003;
   localparam logic [31:0] FQG_D_SYM_512M  = 32'h0200_01FF;
   localparam logic [31:0] FQG_D_SYM_1G    = 32'h0200_03FF;
   // largest part reports the same region geometry as the 1G part
   localparam logic [31:0] FQG_D_SYM_2G    = 32'h0200_03FF;
   localparam logic [31:0] FQG_D_NONE      = 32'h0000_0000;

   // reset value of the data output
   localparam logic [15:0] FQG_DQ_RST = 16'h0000;

   typedef enum logic [1:0] {
      FQG_DEN_512M,
      FQG_DEN_1G,
      FQG_DEN_2G
   } fqg_density_t;

   typedef enum logic [1:0] {
      FQG_LOC_TOP,
      FQG_LOC_BOTTOM,
      FQG_LOC_SYM
   } fqg_ploc_t;

   typedef struct packed {
      fqg_density_t density;
      fqg_ploc_t    ploc;
   } fqg_cfg_t;

   // strap synchroniser value while in reset
   localparam fqg_cfg_t FQG_CFG_RST = '{density: FQG_DEN_512M, ploc: FQG_LOC_TOP};

   typedef struct packed {
      logic       rd;
      logic [7:0] addr;
   } fqg_req_t;

   typedef struct packed {
      logic        hit;
      logic [15:0] dq;
   } fqg_rsp_t;

endpackage

// ---- fqg_region_sel.sv ----
// picks one byte out of a 32-bit erase region descriptor
`timescale 1ns/100ps
module fqg_region_sel
   import fqg_pkg::*;
(
   // descriptor and byte index
   input  wire logic [31:0] i_desc,
   input  wire logic [1:0]  i_idx,
   // selected byte
   output logic      [7:0]  o_byte
);

   // byte 0 is the low byte of the block count minus one, little endian order
   assign o_byte = i_desc[{i_idx, 3'b000} +: 8];

endmodule

// ---- fqg_query_rom.sv ----
// system interface and geometry query table of the flash device
`timescale 1ns/100ps

// Notes on behaviour
// - 1Bh/1Ch give core supply min/max, BCD volts and tenths: 23, 36.
// - 1Dh/1Eh give program supply min/max, hex volts, BCD tenths: 85, 95.
// - 1Fh gives typical word program timeout exponent 09.
// - 20h gives typical buffer write timeout exponent 0A.
// - 21h gives typical block erase timeout exponent 0A.
// - 22h and 26h give 00: chip erase timing not applicable.
// - 23h gives max word program multiplier exponent 01.
// - 24h gives max buffer write multiplier exponent 02.
// - 25h gives max block erase multiplier exponent 02.
// - 27h gives size exponent: 1A for 512 Mbit, 1B for larger.
// - 28h/29h give interface code 01 then 00, x16 capable.
// - 2Ah/2Bh give write buffer exponent 0A then 00.
// - 2Ch gives region count: 02 with parameter blocks, 01 symmetrical.
// - 2Dh..30h describe region 1; low half holds block count minus one.
// - upper half of each descriptor is block size in 256-byte units.
// - 31h..34h describe region 2 with the same encoding.
// - 35h..38h are reserved and read as zero.
// - table byte on low data lane; upper data byte always zero.
module fqg_query_rom
   import fqg_pkg::*;
(
   // clock and reset
   input  wire logic     i_ref_clk,
   input  wire logic     i_rst_b,
   // configuration straps, static during operation
   input  wire fqg_cfg_t i_cfg,
   // read request from the command logic, same clock domain
   input  wire fqg_req_t i_req,
   // answer
   output fqg_rsp_t      o_rsp
);

   // straps are pins; two flops before any decode reads them
   fqg_cfg_t cfg_meta_ff;
   fqg_cfg_t cfg_sync_ff;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cfg_meta_ff <= FQG_CFG_RST;
         cfg_sync_ff <= FQG_CFG_RST;
      end else begin
         cfg_meta_ff <= i_cfg;
         cfg_sync_ff <= cfg_meta_ff;
      end
   end

   // configuration decode
   wire is_512m;
   wire is_2g;
   wire is_top;
   wire is_bottom;
   wire is_sym;

   assign is_512m   = (cfg_sync_ff.density == FQG_DEN_512M);
   assign is_2g     = (cfg_sync_ff.density == FQG_DEN_2G);
   assign is_top    = (cfg_sync_ff.ploc == FQG_LOC_TOP);
   assign is_bottom = (cfg_sync_ff.ploc == FQG_LOC_BOTTOM);
   // the largest density only exists symmetrically blocked
   assign is_sym    = is_2g || (cfg_sync_ff.ploc == FQG_LOC_SYM);

   // per-configuration geometry values
   wire [7:0]  size_val;
   wire [7:0]  nreg_val;
   wire [31:0] main_desc;
   wire [31:0] sym_desc;
   wire [31:0] reg1_desc;
   wire [31:0] reg2_desc;

   assign size_val  = is_512m ? FQG_V_SIZE_512M : FQG_V_SIZE_1G;
   assign nreg_val  = is_sym ? FQG_V_NREG_SYM : FQG_V_NREG_PARM;
   assign main_desc = is_512m ? FQG_D_MAIN_512M : FQG_D_MAIN_1G;
   assign sym_desc  = is_512m ? FQG_D_SYM_512M :
                      (is_2g ? FQG_D_SYM_2G : FQG_D_SYM_1G);
   // top parts list the main blocks first, bottom parts the small ones
   assign reg1_desc = is_sym ? sym_desc :
                      (is_bottom ? FQG_D_PARM : main_desc);
   assign reg2_desc = is_sym ? FQG_D_NONE :
                      (is_top ? FQG_D_PARM : main_desc);

   // region byte selection
   wire       in_reg1;
   wire       in_reg2;
   wire       in_rsvd;
   wire [7:0] off1;
   wire [7:0] off2;
   wire [7:0] reg1_byte;
   wire [7:0] reg2_byte;

   assign in_reg1 = (i_req.addr >= FQG_A_REG1) && (i_req.addr < FQG_A_REG2);
   assign in_reg2 = (i_req.addr >= FQG_A_REG2) && (i_req.addr < FQG_A_RSVD);
   assign in_rsvd = (i_req.addr >= FQG_A_RSVD) && (i_req.addr <= FQG_ADDR_LAST);
   assign off1    = i_req.addr - FQG_A_REG1;
   assign off2    = i_req.addr - FQG_A_REG2;

   fqg_region_sel u_reg1_sel (
      .i_desc (reg1_desc),
      .i_idx  (off1[1:0]),
      .o_byte (reg1_byte)
   );

   fqg_region_sel u_reg2_sel (
      .i_desc (reg2_desc),
      .i_idx  (off2[1:0]),
      .o_byte (reg2_byte)
   );

   // address decode to table byte
   logic [7:0] tbl_byte;
   wire        in_table;

   assign in_table = (i_req.addr >= FQG_ADDR_FIRST) && (i_req.addr <= FQG_ADDR_LAST);

   always_comb begin
      tbl_byte = FQG_V_ZERO;
      case (i_req.addr)
         FQG_A_VCC_MIN: tbl_byte = FQG_V_VCC_MIN;
         FQG_A_VCC_MAX: tbl_byte = FQG_V_VCC_MAX;
         FQG_A_VPP_MIN: tbl_byte = FQG_V_VPP_MIN;
         FQG_A_VPP_MAX: tbl_byte = FQG_V_VPP_MAX;
         FQG_A_TWP_TYP: tbl_byte = FQG_V_TWP_TYP;
         FQG_A_TBW_TYP: tbl_byte = FQG_V_TBW_TYP;
         FQG_A_TBE_TYP: tbl_byte = FQG_V_TBE_TYP;
         FQG_A_TCE_TYP: tbl_byte = FQG_V_TCE;
         FQG_A_TWP_MAX: tbl_byte = FQG_V_TWP_MAX;
         FQG_A_TBW_MAX: tbl_byte = FQG_V_TBW_MAX;
         FQG_A_TBE_MAX: tbl_byte = FQG_V_TBE_MAX;
         FQG_A_TCE_MAX: tbl_byte = FQG_V_TCE;
         FQG_A_SIZE:    tbl_byte = size_val;
         FQG_A_IFC_LO:  tbl_byte = FQG_V_IFC_LO;
         FQG_A_IFC_HI:  tbl_byte = FQG_V_IFC_HI;
         FQG_A_WBUF_LO: tbl_byte = FQG_V_WBUF_LO;
         FQG_A_WBUF_HI: tbl_byte = FQG_V_WBUF_HI;
         FQG_A_NREG:    tbl_byte = nreg_val;
         default: begin
            if (in_reg1) begin
               tbl_byte = reg1_byte;
            end else if (in_reg2) begin
               tbl_byte = reg2_byte;
            end else begin
               // reserved words and anything outside read as zero
               tbl_byte = FQG_V_ZERO;
            end
         end
      endcase
   end

   // registered answer; pure lookup, nothing else changes on a read
   fqg_rsp_t nxt_rsp;
   fqg_rsp_t rsp_ff;

   assign nxt_rsp = '{hit: i_req.rd && in_table,
                      dq:  i_req.rd ? {8'h00, tbl_byte} : FQG_DQ_RST};

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rsp_ff <= '{hit: 1'b0, dq: FQG_DQ_RST};
      end else begin
         rsp_ff <= nxt_rsp;
      end
   end

   assign o_rsp = rsp_ff;

   // checks
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);

   sequence rd_at(logic [7:0] a);
      i_req.rd && (i_req.addr == a);
   endsequence

   // configuration shorthands for the checks
   wire parm_first;
   wire parm_last;

   assign parm_first = is_bottom && !is_sym;
   assign parm_last  = is_top && !is_sym;

   // four back to back reads from word a onwards
   sequence walk4(logic [7:0] a);
      rd_at(a) ##1
      rd_at(a + 8'h01) ##1
      rd_at(a + 8'h02) ##1
      rd_at(a + 8'h03);
   endsequence

   // answers of such a walk one cycle after its last read, low byte first
   sequence walk4_seen(logic [31:0] d);
      ($past(o_rsp.dq[7:0], 3) == d[7:0]) &&
      ($past(o_rsp.dq[7:0], 2) == d[15:8]) &&
      ($past(o_rsp.dq[7:0]) == d[23:16]) &&
      (o_rsp.dq[7:0] == d[31:24]);
   endsequence

   // two back to back reads of a 16-bit field
   sequence walk2(logic [7:0] a);
      rd_at(a) ##1 rd_at(a + 8'h01);
   endsequence

   // answers of such a pair one cycle after the second read
   sequence walk2_seen(logic [15:0] v);
      ($past(o_rsp.dq[7:0]) == v[7:0]) && (o_rsp.dq[7:0] == v[15:8]);
   endsequence

   // a table read followed by a free cycle
   sequence read_then_idle;
      i_req.rd && in_table ##1 !i_req.rd;
   endsequence

   vcc_range_a: assert property (rd_at(FQG_A_VCC_MIN) |=> o_rsp.dq == 16'h0023)
      else $error("core supply minimum byte wrong");
   vpp_range_a: assert property (rd_at(FQG_A_VPP_MAX) |=> o_rsp.dq == 16'h0095)
      else $error("program supply maximum byte wrong");
   word_typ_a: assert property (rd_at(FQG_A_TWP_TYP) |=> o_rsp.dq[7:0] == 8'h09)
      else $error("word program exponent wrong");
   buf_typ_a: assert property (rd_at(FQG_A_TBW_TYP) |=> o_rsp.dq[7:0] == 8'h0A)
      else $error("buffer write exponent wrong");
   erase_typ_a: assert property (rd_at(FQG_A_TBE_TYP) |=> o_rsp.dq[7:0] == 8'h0A)
      else $error("block erase exponent wrong");
   chip_na_a: assert property ((rd_at(FQG_A_TCE_TYP) or rd_at(FQG_A_TCE_MAX))
                               |=> o_rsp.dq == 16'h0000)
      else $error("chip erase code not zero");
   word_max_a: assert property (rd_at(FQG_A_TWP_MAX) |=> o_rsp.dq[7:0] == 8'h01)
      else $error("word program multiplier wrong");
   buf_max_a: assert property (rd_at(FQG_A_TBW_MAX) |=> o_rsp.dq[7:0] == 8'h02)
      else $error("buffer write multiplier wrong");
   erase_max_a: assert property (rd_at(FQG_A_TBE_MAX) |=> o_rsp.dq[7:0] == 8'h02)
      else $error("block erase multiplier wrong");
   size_code_a: assert property (rd_at(FQG_A_SIZE) |=>
                                 o_rsp.dq[7:0] == ($past(is_512m) ? 8'h1A : 8'h1B))
      else $error("size exponent wrong");
   iface_code_a: assert property (rd_at(FQG_A_IFC_LO) ##1 rd_at(FQG_A_IFC_HI) |->
                                  o_rsp.dq == 16'h0001 ##1 o_rsp.dq == 16'h0000)
      else $error("interface code wrong");
   wbuf_size_a: assert property (rd_at(FQG_A_WBUF_LO) |=> o_rsp.dq == 16'h000A)
      else $error("write buffer exponent wrong");
   region_count_a: assert property (rd_at(FQG_A_NREG) |=>
                                    o_rsp.dq[7:0] == ($past(is_sym) ? 8'h01 : 8'h02))
      else $error("region count wrong");
   reg1_first_a: assert property (rd_at(FQG_A_REG1) |=> o_rsp.dq[7:0] ==
                     ($past(is_sym) ? 8'hFF : ($past(is_bottom) ? 8'h03 : 8'hFE)))
      else $error("region 1 count byte wrong");
   reg_size_a: assert property (parm_first ##0 rd_at(8'h2F) |=> o_rsp.dq[7:0] == 8'h80)
      else $error("parameter block size byte wrong");
   reg2_sym_a: assert property (i_req.rd && in_reg2 && is_sym |=> o_rsp.dq == 16'h0000)
      else $error("region 2 not empty when symmetrical");
   rsvd_zero_a: assert property (i_req.rd && in_rsvd |=> o_rsp.dq == 16'h0000)
      else $error("reserved word not zero");
   upper_zero_a: assert property (o_rsp.dq[15:8] == 8'h00)
      else $error("upper data byte not zero");
   repeat_read_a: assert property (i_req.rd ##1 i_req.rd && $stable(i_req.addr) && $stable(cfg_sync_ff)
                                   |=> $stable(o_rsp.dq))
      else $error("repeated read changed answer");

   // single words not covered above
   vcc_max_a: assert property (rd_at(FQG_A_VCC_MAX) |=> o_rsp.dq == 16'h0036)
      else $error("core supply maximum byte wrong");
   vpp_min_a: assert property (rd_at(FQG_A_VPP_MIN) |=> o_rsp.dq == 16'h0085)
      else $error("program supply minimum byte wrong");
   wbuf_hi_a: assert property (rd_at(FQG_A_WBUF_HI) |=> o_rsp.dq == 16'h0000)
      else $error("write buffer upper byte not zero");

   // answer framing; the flag lasts exactly one cycle per table read
   hit_set_a: assert property (i_req.rd && in_table |=> o_rsp.hit)
      else $error("table read not flagged");
   hit_clear_a: assert property (!(i_req.rd && in_table) |=> !o_rsp.hit)
      else $error("flag raised without table read");
   hit_pulse_a: assert property (read_then_idle |->
                                 o_rsp.hit ##1 !o_rsp.hit)
      else $error("flag did not drop after read");
   idle_zero_a: assert property (!i_req.rd |=> o_rsp.dq == 16'h0000)
      else $error("data not zero while idle");
   outside_zero_a: assert property (i_req.rd && !in_table |=> o_rsp.dq == 16'h0000)
      else $error("word outside table not zero");
   region_excl_a: assert property ($onehot0({in_reg1, in_reg2, in_rsvd}))
      else $error("region windows overlap");

   // 16-bit fields read low byte first
   supply_pair_a: assert property (walk2(FQG_A_VCC_MIN) |=> walk2_seen(16'h3623))
      else $error("core supply pair wrong");
   vpp_pair_a: assert property (walk2(FQG_A_VPP_MIN) |=> walk2_seen(16'h9585))
      else $error("program supply pair wrong");
   wbuf_pair_a: assert property (walk2(FQG_A_WBUF_LO) |=> walk2_seen(16'h000A))
      else $error("write buffer pair wrong");

   // timeout and geometry groups read in one run
   typ_walk_a: assert property (walk4(FQG_A_TWP_TYP) |=>
                                walk4_seen(32'h000A_0A09))
      else $error("typical timeout group wrong");
   max_walk_a: assert property (walk4(FQG_A_TWP_MAX) |=>
                                walk4_seen(32'h0002_0201))
      else $error("maximum timeout group wrong");
   ifc_walk_a: assert property (walk4(FQG_A_IFC_LO) |=>
                                walk4_seen(32'h000A_0001))
      else $error("interface and buffer group wrong");
   geo_small_a: assert property (is_512m ##0 walk4(FQG_A_SIZE) |=>
                                 walk4_seen(32'h0A00_011A))
      else $error("small part geometry group wrong");
   geo_large_a: assert property (!is_512m ##0 walk4(FQG_A_SIZE) |=>
                                 walk4_seen(32'h0A00_011B))
      else $error("large part geometry group wrong");

   // erase region descriptors per configuration
   reg1_parm_a: assert property (parm_first ##0 walk4(FQG_A_REG1) |=>
                                 walk4_seen(32'h0080_0003))
      else $error("region 1 parameter descriptor wrong");
   reg2_parm_a: assert property (parm_last ##0 walk4(FQG_A_REG2) |=>
                                 walk4_seen(32'h0080_0003))
      else $error("region 2 parameter descriptor wrong");
   reg1_main_a: assert property (parm_last && is_512m ##0 walk4(FQG_A_REG1) |=>
                                 walk4_seen(32'h0200_01FE))
      else $error("region 1 main descriptor wrong");
   reg1_big_a: assert property (parm_last && !is_512m ##0 walk4(FQG_A_REG1) |=>
                                walk4_seen(32'h0200_03FE))
      else $error("region 1 large main descriptor wrong");
   reg2_main_a: assert property (parm_first && is_512m ##0 walk4(FQG_A_REG2) |=>
                                 walk4_seen(32'h0200_01FE))
      else $error("region 2 main descriptor wrong");
   reg2_big_a: assert property (parm_first && !is_512m ##0 walk4(FQG_A_REG2) |=>
                                walk4_seen(32'h0200_03FE))
      else $error("region 2 large main descriptor wrong");
   reg1_sym_a: assert property (is_sym && is_512m ##0 walk4(FQG_A_REG1) |=>
                                walk4_seen(32'h0200_01FF))
      else $error("region 1 symmetrical descriptor wrong");
   reg1_symbig_a: assert property (is_sym && !is_512m ##0 walk4(FQG_A_REG1) |=>
                                   walk4_seen(32'h0200_03FF))
      else $error("region 1 large symmetrical descriptor wrong");
   reg2_none_a: assert property (is_sym ##0 walk4(FQG_A_REG2) |=>
                                 walk4_seen(32'h0000_0000))
      else $error("region 2 descriptor not empty");
   rsvd_walk_a: assert property (walk4(FQG_A_RSVD) |=>
                                 walk4_seen(32'h0000_0000))
      else $error("reserved descriptor not empty");
   bulk_never_a: assert property (rd_at(FQG_A_NREG) |=> o_rsp.dq[7:0] != 8'h00)
      else $error("region count reads as bulk only");

endmodule

// ---- fqg_host_model.sv ----
// host side model issuing query reads to the geometry table
`timescale 1ns/100ps
module fqg_host_model
   import fqg_pkg::*;
(
   // clock
   input  wire logic     i_ref_clk,
   // answer from the table
   input  wire fqg_rsp_t i_rsp,
   // request to the table
   output fqg_req_t      o_req
);
   logic     query_mode_ff;
   fqg_rsp_t seen [0:63];

   initial begin
      o_req         = '0;
      query_mode_ff = 1'b0;
   end

   // no table read is issued before the query command
   task automatic enter_query();
      query_mode_ff = 1'b1;
   endtask

   // back to back reads; seen[n] holds the idle cycle after the last one
   task automatic read_burst(input logic [7:0] first, input int n);
      for (int i = 0; i <= n; i++) begin
         @(posedge i_ref_clk);
         #1;
         if (i > 0) seen[i-1] = i_rsp;
         o_req.rd   = query_mode_ff && (i < n);
         // released address flips so a stale value never looks valid
         o_req.addr = (i < n) ? first + 8'(i) : ~o_req.addr;
      end
      @(posedge i_ref_clk);
      #1;
      seen[n] = i_rsp;
   endtask

   task automatic hold_read(input logic [7:0] a);
      @(posedge i_ref_clk);
      #1;
      o_req.rd   = query_mode_ff;
      o_req.addr = a;
   endtask

   task automatic release_read();
      @(posedge i_ref_clk);
      #1;
      o_req.rd   = 1'b0;
      o_req.addr = ~o_req.addr;
   endtask

   // a region count of zero means the part erases only in bulk
   function automatic logic is_bulk_only(input logic [7:0] count);
      return count == 8'h00;
   endfunction
endmodule

// ---- fqg_query_rom_bench.sv ----
// self-checking bench for the query geometry table
`timescale 1ns/100ps
module fqg_query_rom_bench
   import fqg_pkg::*;
;
   logic     i_ref_clk;
   logic     i_rst_b;
   fqg_cfg_t i_cfg;
   fqg_req_t req;
   fqg_rsp_t rsp;
   int       num_errors;
   int       samples_checked;

   fqg_query_rom uut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_cfg(i_cfg), .i_req(req), .o_rsp(rsp));
   fqg_host_model host (.i_ref_clk(i_ref_clk), .i_rsp(rsp), .o_req(req));

   initial begin
      i_ref_clk = 1'b0;
      forever #50 i_ref_clk = ~i_ref_clk;
   end

   task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // table byte at word a, zero outside 1Bh..38h
   function automatic logic [7:0] exp_byte(input fqg_density_t d, input fqg_ploc_t p, input logic [7:0] a);
      logic             sym;
      logic [15:0]      y;
      logic [31:0]      main_d;
      logic [31:0]      r1;
      logic [31:0]      r2;
      logic [0:29][7:0] tbl;
      // 2G parts only come symmetrical
      sym    = (p == FQG_LOC_SYM) || (d == FQG_DEN_2G);
      // the 2G part reports the 1G region geometry
      y      = ((d == FQG_DEN_512M) ? 16'h0200 : 16'h0400) - (sym ? 16'h0001 : 16'h0002);
      main_d = {16'h0200, y};
      r1     = (sym || p == FQG_LOC_TOP) ? main_d : 32'h0080_0003;
      r2     = sym ? 32'h0000_0000 : ((p == FQG_LOC_TOP) ? 32'h0080_0003 : main_d);
      tbl    = {8'h23, 8'h36, 8'h85, 8'h95, 8'h09, 8'h0A, 8'h0A, 8'h00, 8'h01, 8'h02, 8'h02, 8'h00,
                (d == FQG_DEN_512M) ? 8'h1A : 8'h1B, 8'h01, 8'h00, 8'h0A, 8'h00, sym ? 8'h01 : 8'h02,
                r1[7:0], r1[15:8], r1[23:16], r1[31:24], r2[7:0], r2[15:8], r2[23:16], r2[31:24],
                32'h0000_0000};
      return ((a >= 8'h1B) && (a <= 8'h38)) ? tbl[a - 8'h1B] : 8'h00;
   endfunction

   task automatic test_table(input fqg_density_t d, input fqg_ploc_t p);
      logic [7:0] a;
      logic       hit;
      @(posedge i_ref_clk);
      #1;
      i_cfg = '{d, p};
      // straps pass two flops before the table sees them
      repeat (2) @(posedge i_ref_clk);
      host.read_burst(8'h1A, 32);
      for (int i = 0; i < 32; i++) begin
         a   = 8'h1A + 8'(i);
         hit = (a >= 8'h1B) && (a <= 8'h38);
         check("table word", host.seen[i], {hit, 8'h00, exp_byte(d, p, a)});
      end
      check("idle word", host.seen[32], 17'h0_0000);
      check("bulk only", {16'h0000, host.is_bulk_only(host.seen[18].dq[7:0])}, 17'h0_0000);
      $display("test table %0d/%0d done", d, p);
   endtask

   task automatic test_out_of_range();
      host.read_burst(8'hFE, 3);
      for (int i = 0; i < 4; i++) begin
         check("outside word", host.seen[i], 17'h0_0000);
      end
      $display("test out of range done");
   endtask

   task automatic test_reset_midrun();
      host.hold_read(8'h1B);
      @(posedge i_ref_clk);
      #1;
      check("held read", rsp, {1'b1, 16'h0023});
      i_rst_b = 1'b0;
      #1;
      check("async clear", rsp, 17'h0_0000);
      repeat (2) @(posedge i_ref_clk);
      #1;
      i_rst_b = 1'b1;
      @(posedge i_ref_clk);
      #1;
      check("after reset", rsp, {1'b1, 16'h0023});
      host.release_read();
      @(posedge i_ref_clk);
      #1;
      check("released", rsp, 17'h0_0000);
      $display("test reset midrun done");
   endtask

   task automatic wrap_up();
      $display("checked %0d samples, %0d mismatches", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      i_rst_b = 1'b0;
      i_cfg   = '{FQG_DEN_512M, FQG_LOC_TOP};
      repeat (10) @(posedge i_ref_clk);
      #1;
      check("reset rsp", rsp, 17'h0_0000);
      i_rst_b = 1'b1;
      host.enter_query();
      for (int d = 0; d < 3; d++) begin
         for (int p = 0; p < 3; p++) begin
            test_table(fqg_density_t'(d), fqg_ploc_t'(p));
         end
      end
      test_out_of_range();
      test_reset_midrun();
      wrap_up();
   end

   // nine table walks of about 35 cycles each, with a wide margin
   initial begin
      #(2000 * 100);
      num_errors++;
      wrap_up();
   end
endmodule
